//--- src/pfsw_pkg.sv
`default_nettype none
package pfsw_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_ADDR_LOW  = 8'h00;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFF_DATA_LOW  = 8'h08;
  localparam logic [7:0] OFF_DATA_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CONTROL   = 8'h10;
  localparam logic [7:0] OFF_UNLOCK    = 8'h14;
  // Control register bit positions
  localparam int CTL_RD   = 0;
  localparam int CTL_WR   = 1;
  localparam int CTL_WRITE_ENABLE = 2;
  localparam int CTL_ERR  = 3;
  localparam int CTL_FREE = 4;
  localparam int CTL_LATCH_LOAD_ONLY = 5;
  localparam int CTL_CONFIG_SPACE_SELECT = 6;
  localparam int CTL_PGD  = 7;
  // Geometry
  localparam int ADDR_W  = 15;
  localparam int WORD_W  = 14;
  localparam int LAT_N   = 32;
  localparam int LAT_W   = 5;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Write latch idle value
  localparam logic [13:0] LATCH_ERASED = 14'h3FFF;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BUSY_TIME_MS  = 2;
  localparam int BUSY_CYC      = BUSY_TIME_MS * 1000000000 / CLK_PERIOD_PS;
  localparam int SETUP_CYC     = 2;
  // Protected segment upper bounds per protect field code
  localparam logic [14:0] WP_LIMIT_0 = 15'h1000;
  localparam logic [14:0] WP_LIMIT_1 = 15'h0800;
  localparam logic [14:0] WP_LIMIT_2 = 15'h0200;
  localparam logic [14:0] WP_LIMIT_3 = 15'h0000;
  // Flash array request bundle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        erase;
    logic [14:0] addr;
    logic [13:0] wdata;
  } pfsw_flash_req_type;
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_RD_WAIT, S_RD_ACC, S_RD_CAP, S_SETUP, S_ERASE, S_PROG, S_BUSY, S_DONE
  } pfsw_state_type;
endpackage : pfsw_pkg
`default_nettype wire

//--- src/pfsw_ctrl.sv
// Function
// - Read steals second instruction cycle
// - Read data lands next cycle, held
// - Reads ignore code protection
// - Erase only whole rows at address
// - Start needs 55h, AAh, then write start
// - Erase select bit shows erase progress
// - Two setup cycles after write start
// - Erase stalls CPU about 2ms, clocks run
// - Resume at third instruction after start
// - Write never erases; software targets erased words
// - Block write stays within latch boundary
// - Latches return to 0x3FFF after write
// - Load-only mode fills one latch, no stall
// - Load-only clear programs whole latch block
// - Unloaded latches keep contents, all programmed
// - Only final programming stalls about 2ms
// - Write start refused without write enable
// - Protected segment never erased or written
// - Write enable cleared at power-up
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pfsw_ctrl #(
  parameter int BUSY_CYCLES = pfsw_pkg::BUSY_CYC  // Busy time in clocks
) (
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic [31:0]                       hrdata,
  output pfsw_pkg::pfsw_flash_req_type      flash_req,
  input  wire logic [13:0]                  flash_rdata,
  input  wire logic [1:0]                   cfg_write_protect,
  output logic                              cpu_stall,
  output logic                              cpu_steal
);
  localparam int CW = $clog2(BUSY_CYCLES + 1);
  // Programming walk must fit inside the busy time
  if (BUSY_CYCLES <= pfsw_pkg::LAT_N + pfsw_pkg::SETUP_CYC) begin : g_busy_check
    $error("BUSY_CYCLES too small");
  end
  // Write-protect decode, also used by assertions
  function automatic logic wp_hit(input logic [1:0] f, input logic [14:0] a);
    logic [14:0] lim;
    lim = pfsw_pkg::WP_LIMIT_3;
    unique case (f)
      2'd0: lim = pfsw_pkg::WP_LIMIT_0;
      2'd1: lim = pfsw_pkg::WP_LIMIT_1;
      2'd2: lim = pfsw_pkg::WP_LIMIT_2;
      2'd3: lim = pfsw_pkg::WP_LIMIT_3;
    endcase
    return a < lim;
  endfunction : wp_hit
  // Bus pipeline state
  logic [7:0]  aoff_q;     // Latched register offset
  logic        wpend_q;    // Write data phase pending
  logic        rwait_q;    // Read wait state
  logic [31:0] hrdata_q;   // Registered read data
  // Software registers
  logic [7:0]  addr_low_q;
  logic [6:0]  addr_high_q;
  logic [7:0]  data_low_q;
  logic [5:0]  data_high_q;
  logic        rd_q, wr_q, write_enable_q, err_q;
  logic        free_q, latch_load_only_q, config_space_select_q, pgd_q;
  logic [1:0]  unl_q;      // 0 none, 1 first key, 2 armed
  // Sequencer
  pfsw_pkg::pfsw_state_type st_q;
  logic [CW-1:0]           cnt_q;
  logic [4:0]              idx_q;
  logic [13:0]             latch_q [pfsw_pkg::LAT_N];
  // Address phase and write decode
  wire         aphase   = hsel && hready && htrans[1];
  wire         rd_req   = aphase && !hwrite;
  wire         wr_ctl   = wpend_q && aoff_q == pfsw_pkg::OFF_CONTROL;
  wire         wr_unl   = wpend_q && aoff_q == pfsw_pkg::OFF_UNLOCK;
  wire         idle     = st_q == pfsw_pkg::S_IDLE;
  wire         armed    = unl_q == 2'd2;
  wire [14:0]  addr     = {addr_high_q, addr_low_q};
  wire [13:0]  data_w   = {data_high_q, data_low_q};
  wire [4:0]   lat_sel  = addr_low_q[4:0];
  // Read start: program space only; code protect not consulted
  wire start_rd = wr_ctl && idle && hwdata[pfsw_pkg::CTL_RD]
                  && hwdata[pfsw_pkg::CTL_PGD] && !hwdata[pfsw_pkg::CTL_CONFIG_SPACE_SELECT];
  // Write start needs armed unlock and prior enable
  wire start_wr = wr_ctl && idle && hwdata[pfsw_pkg::CTL_WR] && armed && write_enable_q
                  && hwdata[pfsw_pkg::CTL_PGD] && !hwdata[pfsw_pkg::CTL_CONFIG_SPACE_SELECT];
  // Setup finished this cycle
  wire setup_end = st_q == pfsw_pkg::S_SETUP && cnt_q == '0;
  // Erase and program both refused in protected segment
  wire prot      = wp_hit(cfg_write_protect, addr);
  wire do_load   = setup_end && !prot && !free_q;   // Latch fill
  wire do_erase  = setup_end && !prot && free_q;
  wire do_prog   = do_load && !latch_load_only_q;
  wire last_prog = st_q == pfsw_pkg::S_PROG && idx_q == 5'(pfsw_pkg::LAT_N - 1);
  // Latches return to erased value when programming ends
  wire latch_clr = st_q == pfsw_pkg::S_BUSY && cnt_q == '0 && !free_q;  // Load-only never clears
  // Zero wait on writes, one wait on reads
  assign hreadyout = !rwait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  // Read data mux; unlock port and holes read zero
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (aoff_q)
      pfsw_pkg::OFF_ADDR_LOW:  rmux = {24'h000000, addr_low_q};
      pfsw_pkg::OFF_ADDR_HIGH: rmux = {25'h0000000, addr_high_q};
      pfsw_pkg::OFF_DATA_LOW:  rmux = {24'h000000, data_low_q};
      pfsw_pkg::OFF_DATA_HIGH: rmux = {26'h0000000, data_high_q};
      pfsw_pkg::OFF_CONTROL:   rmux = {24'h000000, pgd_q, config_space_select_q, latch_load_only_q, free_q,
                                        err_q, write_enable_q, wr_q, rd_q};
      default:                 rmux = 32'h0000_0000;
    endcase
  end
  // Bus pipeline; reads sample a cycle late so prior writes land
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aoff_q   <= 8'h00;
      wpend_q  <= 1'b0;
      rwait_q  <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      if (aphase) begin
        aoff_q <= haddr[7:0];
      end
      wpend_q <= aphase && hwrite;
      rwait_q <= rd_req;
      if (rwait_q) begin
        hrdata_q <= rmux;
      end
    end
  end
  // Address registers, software only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_low_q  <= 8'h00;
      addr_high_q <= 7'h00;
    end else if (wpend_q) begin
      if (aoff_q == pfsw_pkg::OFF_ADDR_LOW) begin
        addr_low_q <= hwdata[7:0];
      end
      if (aoff_q == pfsw_pkg::OFF_ADDR_HIGH) begin
        addr_high_q <= hwdata[6:0];
      end
    end
  end
  // Data registers; flash read capture beats software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_low_q  <= 8'h00;
      data_high_q <= 6'h00;
    end else if (st_q == pfsw_pkg::S_RD_CAP) begin
      data_low_q  <= flash_rdata[7:0];
      data_high_q <= flash_rdata[13:8];
    end else if (wpend_q) begin
      if (aoff_q == pfsw_pkg::OFF_DATA_LOW) begin
        data_low_q <= hwdata[7:0];
      end
      if (aoff_q == pfsw_pkg::OFF_DATA_HIGH) begin
        data_high_q <= hwdata[5:0];
      end
    end
  end
  // Unlock tracker; any other write breaks the sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unl_q <= 2'd0;
    end else if (wpend_q) begin
      if (wr_unl && hwdata[7:0] == pfsw_pkg::KEY_FIRST) begin
        unl_q <= 2'd1;
      end else if (wr_unl && hwdata[7:0] == pfsw_pkg::KEY_SECOND && unl_q == 2'd1) begin
        unl_q <= 2'd2;
      end else begin
        unl_q <= 2'd0;
      end
    end
  end
  // Control bits; mode bits frozen while a cycle runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_enable_q <= 1'b0;  // Off at power-up
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      err_q  <= 1'b0;
      free_q <= 1'b0;
      latch_load_only_q <= 1'b0;
      config_space_select_q <= 1'b0;
      pgd_q  <= 1'b0;
    end else begin
      if (wr_ctl) begin
        write_enable_q <= hwdata[pfsw_pkg::CTL_WRITE_ENABLE];  // May drop mid-cycle without abort
      end
      if (wr_ctl && idle) begin
        free_q <= hwdata[pfsw_pkg::CTL_FREE];
        latch_load_only_q <= hwdata[pfsw_pkg::CTL_LATCH_LOAD_ONLY];
        config_space_select_q <= hwdata[pfsw_pkg::CTL_CONFIG_SPACE_SELECT];
        pgd_q  <= hwdata[pfsw_pkg::CTL_PGD];
        err_q  <= err_q && hwdata[pfsw_pkg::CTL_ERR];
      end
      if (setup_end && prot) begin
        err_q <= 1'b1;  // Set wins over a clearing write
      end
      // Read request bit lives until capture
      if (start_rd) begin
        rd_q <= 1'b1;
      end else if (st_q == pfsw_pkg::S_RD_CAP) begin
        rd_q <= 1'b0;
      end
      // Write start cleared on completion
      if (start_wr) begin
        wr_q <= 1'b1;
      end else if (st_q == pfsw_pkg::S_DONE) begin
        wr_q <= 1'b0;
      end
      // Erase select drops when erase ends
      if (st_q == pfsw_pkg::S_DONE) begin
        free_q <= 1'b0;
      end
    end
  end
  // Sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q  <= pfsw_pkg::S_IDLE;
      cnt_q <= '0;
      idx_q <= 5'h00;
    end else begin
      unique case (st_q)
        pfsw_pkg::S_IDLE: begin
          if (start_rd) begin
            st_q <= pfsw_pkg::S_RD_WAIT;
          end else if (start_wr) begin
            st_q  <= pfsw_pkg::S_SETUP;  // Two setup cycles
            cnt_q <= CW'(pfsw_pkg::SETUP_CYC - 1);
          end
        end
        pfsw_pkg::S_RD_WAIT: st_q <= pfsw_pkg::S_RD_ACC;  // First instruction after the read runs
        pfsw_pkg::S_RD_ACC:  st_q <= pfsw_pkg::S_RD_CAP;
        pfsw_pkg::S_RD_CAP:  st_q <= pfsw_pkg::S_IDLE;
        pfsw_pkg::S_SETUP: begin
          cnt_q <= cnt_q - CW'(1);
          if (cnt_q == '0) begin
            // Load-only returns at once, no stall
            if (do_erase) begin
              st_q <= pfsw_pkg::S_ERASE;
            end else if (do_prog) begin
              st_q  <= pfsw_pkg::S_PROG;
              idx_q <= 5'h00;
            end else begin
              st_q <= pfsw_pkg::S_DONE;
            end
          end
        end
        pfsw_pkg::S_ERASE: begin
          st_q  <= pfsw_pkg::S_BUSY;  // Erase time
          cnt_q <= CW'(BUSY_CYCLES - 2);
        end
        pfsw_pkg::S_PROG: begin
          idx_q <= idx_q + 5'h01;
          if (last_prog) begin
            st_q  <= pfsw_pkg::S_BUSY;  // Program time
            cnt_q <= CW'(BUSY_CYCLES - pfsw_pkg::LAT_N - 1);
          end
        end
        pfsw_pkg::S_BUSY: begin
          cnt_q <= cnt_q - CW'(1);
          if (cnt_q == '0) begin
            st_q <= pfsw_pkg::S_DONE;
          end
        end
        pfsw_pkg::S_DONE: st_q <= pfsw_pkg::S_IDLE;  // Stall lifted; third instruction runs next
      endcase
    end
  end
  // Write latches; unloaded ones keep contents
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < pfsw_pkg::LAT_N; i++) begin
        latch_q[i] <= pfsw_pkg::LATCH_ERASED;
      end
    end else if (latch_clr) begin
      for (int i = 0; i < pfsw_pkg::LAT_N; i++) begin
        latch_q[i] <= pfsw_pkg::LATCH_ERASED;
      end
    end else if (do_load) begin
      latch_q[lat_sel] <= data_w;
    end
  end
  // Flash request; row and block base from address
  always_comb begin
    flash_req       = '0;
    flash_req.rd    = st_q == pfsw_pkg::S_RD_ACC;
    flash_req.erase = st_q == pfsw_pkg::S_ERASE;  // Writes never erase
    flash_req.wr    = st_q == pfsw_pkg::S_PROG;
    flash_req.addr  = flash_req.erase ? {addr[14:5], 5'h00} : addr;
    if (st_q == pfsw_pkg::S_PROG) begin
      flash_req.addr  = {addr[14:5], idx_q};
      flash_req.wdata = latch_q[idx_q];
    end
  end
  // Stall only for erase and final programming; peripherals run on
  assign cpu_stall = st_q == pfsw_pkg::S_ERASE || st_q == pfsw_pkg::S_PROG
                     || st_q == pfsw_pkg::S_BUSY;
  assign cpu_steal = st_q == pfsw_pkg::S_RD_ACC;
  // Checks
  property p_steal;
    @(posedge hclk) disable iff (!hresetn) start_rd |=> ##1 cpu_steal && flash_req.rd;
  endproperty
  a_steal: assert property (p_steal) else $error("read cycle not stolen");
  property p_rdata;
    @(posedge hclk) disable iff (!hresetn)
      cpu_steal ##1 1'b1 |=> data_low_q == $past(flash_rdata[7:0]) && data_high_q == $past(flash_rdata[13:8]);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not captured");
  property p_wrgate;
    @(posedge hclk) disable iff (!hresetn) $rose(wr_q) |-> $past(write_enable_q) && $past(unl_q) == 2'd2;
  endproperty
  a_wrgate: assert property (p_wrgate) else $error("write start without unlock");
  property p_setup;
    @(posedge hclk) disable iff (!hresetn) $rose(wr_q) |-> !cpu_stall [*2];
  endproperty
  a_setup: assert property (p_setup) else $error("setup cycles stalled");
  property p_erase;
    @(posedge hclk) disable iff (!hresetn) flash_req.erase |-> cpu_stall [*8] ##0 free_q;
  endproperty
  a_erase: assert property (p_erase) else $error("erase stall short");
  property p_load;
    @(posedge hclk) disable iff (!hresetn) do_load && latch_load_only_q |=> !cpu_stall && latch_q[$past(lat_sel)] == $past(data_w);
  endproperty
  a_load: assert property (p_load) else $error("latch load wrong");
  property p_clr;
    @(posedge hclk) disable iff (!hresetn) latch_clr |=> latch_q[0] == pfsw_pkg::LATCH_ERASED;
  endproperty
  a_clr: assert property (p_clr) else $error("latches not reset");
  property p_done;
    @(posedge hclk) disable iff (!hresetn) $fell(cpu_stall) |=> !wr_q;
  endproperty
  a_done: assert property (p_done) else $error("write start not cleared");
  property p_prot;
    @(posedge hclk) disable iff (!hresetn)
      (flash_req.wr || flash_req.erase) |-> !wp_hit(cfg_write_protect, flash_req.addr);
  endproperty
  a_prot: assert property (p_prot) else $error("protected segment touched");
  property p_block;
    @(posedge hclk) disable iff (!hresetn) flash_req.wr |-> flash_req.addr[14:5] == addr[14:5];
  endproperty
  a_block: assert property (p_block) else $error("block boundary crossed");
  c_read:  cover property (@(posedge hclk) start_rd ##3 idle);
  c_erase: cover property (@(posedge hclk) flash_req.erase);
  c_prog:  cover property (@(posedge hclk) last_prog);
  c_load:  cover property (@(posedge hclk) do_load && latch_load_only_q);
endmodule : pfsw_ctrl
`default_nettype wire

//--- testbench/pfsw_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pfsw_ctrl_tb;
  // Busy time kept short so a run stays small
  localparam int          BUSY   = 64;
  localparam logic [31:0] B_RD   = 32'h1 << pfsw_pkg::CTL_RD;
  localparam logic [31:0] B_WR   = 32'h1 << pfsw_pkg::CTL_WR;
  localparam logic [31:0] B_WRITE_ENABLE = 32'h1 << pfsw_pkg::CTL_WRITE_ENABLE;
  localparam logic [31:0] B_ERR  = 32'h1 << pfsw_pkg::CTL_ERR;
  localparam logic [31:0] B_FREE = 32'h1 << pfsw_pkg::CTL_FREE;
  localparam logic [31:0] B_LATCH_LOAD_ONLY = 32'h1 << pfsw_pkg::CTL_LATCH_LOAD_ONLY;
  localparam logic [31:0] B_CONFIG_SPACE_SELECT = 32'h1 << pfsw_pkg::CTL_CONFIG_SPACE_SELECT;
  localparam logic [31:0] B_PGD  = 32'h1 << pfsw_pkg::CTL_PGD;
  // Bus side
  logic                         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]                  haddr, hwdata, hrdata, r;
  logic [1:0]                   htrans, cfg_write_protect;
  logic [2:0]                   hsize;
  // Flash array side
  logic [13:0]                  flash_rdata, d;
  pfsw_pkg::pfsw_flash_req_type flash_req;
  logic                         cpu_stall, cpu_steal;
  logic [14:0]                  erase_addr;
  // Flash contents as the array sees them, and as the rules predict
  logic [13:0]                  fmem [int];
  logic [13:0]                  exp_mem [int];
  logic [13:0]                  lat [32];
  int                           n_mismatch, n_compared, seed, n_erase, n_prog, n_stall, n_steal, s, p, i;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  pfsw_ctrl #(.BUSY_CYCLES(BUSY)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .flash_req(flash_req), .flash_rdata(flash_rdata),
    .cfg_write_protect(cfg_write_protect), .cpu_stall(cpu_stall), .cpu_steal(cpu_steal)
  );

  // Clock generator
  always #2.5 hclk = ~hclk;

  // Flash array model; data line toggles outside a read so stale data never matches
  always @(posedge hclk) begin
    if (flash_req.rd === 1'b1)
      flash_rdata <= fmem.exists(flash_req.addr) ? fmem[flash_req.addr] : 14'h3FFF;
    else
      flash_rdata <= ~flash_rdata;
    if (flash_req.erase === 1'b1) begin
      n_erase++;
      erase_addr = flash_req.addr;
      for (int k = 0; k < 32; k++) fmem[{flash_req.addr[14:5], 5'(k)}] = 14'h3FFF;
    end
    if (flash_req.wr === 1'b1) begin
      n_prog++;
      fmem[flash_req.addr] = flash_req.wdata;
    end
    if (cpu_stall === 1'b1) n_stall++;
    if (cpu_steal === 1'b1) n_steal++;
  end

  // Closing report
  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Single compare for every value kind
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One AHB-Lite single transfer; both phases wait for ready under a bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 50) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : xfer

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] t;
    xfer(1'b1, a, wd, t);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] rd);
    xfer(1'b0, a, 32'h0, rd);
  endtask : bus_rd

  // Address pair load
  task automatic set_addr(input logic [14:0] a);
    bus_wr(pfsw_pkg::OFF_ADDR_LOW, {24'h0, a[7:0]});
    bus_wr(pfsw_pkg::OFF_ADDR_HIGH, {25'h0, a[14:8]});
  endtask : set_addr

  // Poll until start bits drop; polling bounded so a hang ends the run
  task automatic wait_idle;
    logic [31:0] t;
    int n;
    for (n = 0; n < 200; n++) begin
      bus_rd(pfsw_pkg::OFF_CONTROL, t);
      if ((t & (B_RD | B_WR)) == 32'h0) break;
    end
    if (n >= 200) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_idle

  // Mode first with enable, then keys, then start
  task automatic go(input logic [31:0] ctl);
    bus_wr(pfsw_pkg::OFF_CONTROL, ctl);
    bus_wr(pfsw_pkg::OFF_UNLOCK, {24'h0, pfsw_pkg::KEY_FIRST});
    bus_wr(pfsw_pkg::OFF_UNLOCK, {24'h0, pfsw_pkg::KEY_SECOND});
    bus_wr(pfsw_pkg::OFF_CONTROL, ctl | B_WR);
    wait_idle();
  endtask : go

  // Data pair load followed by an unlocked start
  task automatic load(input logic [14:0] a, input logic [13:0] wd, input logic [31:0] ctl);
    set_addr(a);
    bus_wr(pfsw_pkg::OFF_DATA_LOW, {24'h0, wd[7:0]});
    bus_wr(pfsw_pkg::OFF_DATA_HIGH, {26'h0, wd[13:8]});
    go(ctl);
  endtask : load

  // Program word read through the block, compared with the prediction
  task automatic check_word(input int a);
    logic [31:0] lo, hi;
    int st;
    set_addr(15'(a));
    st = n_steal;
    bus_wr(pfsw_pkg::OFF_CONTROL, B_PGD | B_RD);
    wait_idle();
    chk("steal count", 32'h1, n_steal - st);
    bus_rd(pfsw_pkg::OFF_DATA_LOW, lo);
    bus_rd(pfsw_pkg::OFF_DATA_HIGH, hi);
    chk("flash read", exp_mem.exists(a) ? exp_mem[a] : 14'h3FFF, {hi[5:0], lo[7:0]});
  endtask : check_word

  // Main sequence
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; flash_rdata = 14'h0; cfg_write_protect = 2'h2; seed = 90;
    n_mismatch = 0; n_compared = 0; n_erase = 0; n_prog = 0; n_stall = 0; n_steal = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset state, unmapped and unlock reads
    bus_rd(pfsw_pkg::OFF_CONTROL, r);
    chk("control", 32'h0, r);
    bus_wr(8'h18, 32'hFFFFFFFF);
    bus_rd(8'h18, r);
    chk("unmapped", 32'h0, r);
    bus_wr(pfsw_pkg::OFF_UNLOCK, {24'h0, pfsw_pkg::KEY_FIRST});
    bus_rd(pfsw_pkg::OFF_UNLOCK, r);
    chk("unlock read", 32'h0, r);
    $display("Test reset done");
    // Read with configuration space selected is refused
    s = n_steal;
    bus_wr(pfsw_pkg::OFF_CONTROL, B_PGD | B_CONFIG_SPACE_SELECT | B_RD);
    bus_rd(pfsw_pkg::OFF_CONTROL, r);
    chk("control", B_PGD | B_CONFIG_SPACE_SELECT, r);
    chk("steal count", 32'h0, n_steal - s);
    // Start without write enable is refused
    set_addr(15'h1200);
    bus_wr(pfsw_pkg::OFF_CONTROL, B_PGD | B_FREE);
    bus_wr(pfsw_pkg::OFF_UNLOCK, {24'h0, pfsw_pkg::KEY_FIRST});
    bus_wr(pfsw_pkg::OFF_UNLOCK, {24'h0, pfsw_pkg::KEY_SECOND});
    bus_wr(pfsw_pkg::OFF_CONTROL, B_PGD | B_FREE | B_WR);
    bus_rd(pfsw_pkg::OFF_CONTROL, r);
    chk("control", B_PGD | B_FREE, r);
    chk("erase count", 32'h0, n_erase);
    $display("Test refuse done");
    // Row erase of a row holding old data; the next row must survive
    for (i = 0; i < 64; i++) begin
      d = 14'($random(seed));
      fmem[32'h1200 + i] = d;
      exp_mem[32'h1200 + i] = d;
    end
    s = n_stall;
    go(B_PGD | B_FREE | B_WRITE_ENABLE);
    chk("erase count", 32'h1, n_erase);
    chk("erase addr", 32'h1200, {17'h0, erase_addr});
    chk("stall cycles", BUSY, n_stall - s);
    bus_rd(pfsw_pkg::OFF_CONTROL, r);
    chk("control", B_PGD | B_WRITE_ENABLE, r);
    for (i = 0; i < 32; i++) exp_mem[32'h1200 + i] = 14'h3FFF;
    check_word(32'h1211);
    check_word(32'h1225);
    $display("Test erase done");
    // Block write: some latches loaded, then final latch programs the block
    s = n_stall;
    p = n_prog;
    for (i = 0; i < 31; i++) begin
      lat[i] = 14'h3FFF;
      if (i < 10 || i == 20) begin
        lat[i] = 14'($random(seed));
        load(15'(32'h1200 + i), lat[i], B_PGD | B_WRITE_ENABLE | B_LATCH_LOAD_ONLY);
      end
    end
    chk("load stall", 32'h0, n_stall - s);
    chk("load prog", 32'h0, n_prog - p);
    lat[31] = 14'($random(seed));
    load(15'h121F, lat[31], B_PGD | B_WRITE_ENABLE);
    chk("stall cycles", BUSY, n_stall - s);
    chk("prog cycles", 32'd32, n_prog - p);
    for (i = 0; i < 32; i++) begin
      exp_mem[32'h1200 + i] = lat[i];
      chk("flash word", lat[i], fmem[32'h1200 + i]);
    end
    for (i = 0; i < 4; i++) check_word(32'h1200 + ($unsigned($random(seed)) % 32));
    $display("Test block write done");
    // Only the last latch loaded: earlier latches must be back to all ones
    d = 14'($random(seed));
    load(15'h125F, d, B_PGD | B_WRITE_ENABLE);
    for (i = 0; i < 31; i++) chk("flash word", 14'h3FFF, fmem[32'h1240 + i]);
    chk("flash word", d, fmem[32'h125F]);
    $display("Test latch reset done");
    // Protected segment: no erase, error flag raised
    cfg_write_protect <= 2'h0;
    d = 14'($random(seed));
    fmem[32'h0040] = d;
    exp_mem[32'h0040] = d;
    s = n_erase;
    set_addr(15'h0040);
    go(B_PGD | B_FREE | B_WRITE_ENABLE);
    chk("erase count", 32'h0, n_erase - s);
    bus_rd(pfsw_pkg::OFF_CONTROL, r);
    chk("error flag", B_ERR, r & B_ERR);
    bus_wr(pfsw_pkg::OFF_CONTROL, 32'h0);
    check_word(32'h0040);
    $display("Test protect done");
    // Software write to the data low register is kept
    bus_wr(pfsw_pkg::OFF_DATA_LOW, 32'h5A);
    bus_rd(pfsw_pkg::OFF_DATA_LOW, r);
    chk("data low", 32'h5A, r);
    $display("Test data hold done");
    print_verdict();
  end
endmodule : pfsw_ctrl_tb
`default_nettype wire
